// file: core/twcp_consts.svh
// constants of the three-wire control port: widths, reset values, timing
//
// ==================================================================
// Behaviour
// - each rising shift clock edge shifts exactly one data bit in
// - a control word is sixteen bits sent serially on the data line
// - words go most significant bit first; last shifted bit is the LSB
// - latch strobe rising edge copies the sixteen parallel bits into the control word
// - continuous back to back words and isolated single bursts both work
// - serial port responds in software mode only, never in hardware mode
// - mode select input chooses software mode or pin-set hardware mode
// - control word updates start only after the reset initialization period
// - port activity during initialization never changes the control word
// - shift register has no reset and keeps shifting during initialization
// - after initialization in software mode any latch rise copies whatever the shift register holds
// - in hardware mode latch and shift clock are ignored by the control logic
`ifndef TWCP_CONSTS_SVH
`define TWCP_CONSTS_SVH

// ==================================================================
// word layout
`define TWCP_WORD_W 16
`define TWCP_WORD_RESET 16'h0000

// ==================================================================
// timing: system clock and the initialization period after reset
`define TWCP_CLK_PERIOD_NS 40
`define TWCP_INIT_TIME_NS 40960
`define TWCP_INIT_CYCLES ((`TWCP_INIT_TIME_NS + `TWCP_CLK_PERIOD_NS - 1) / `TWCP_CLK_PERIOD_NS)
`define TWCP_INIT_CNT_W 16

// ==================================================================
// synchroniser reset levels
`define TWCP_EXT_RESET_IDLE 1'b1
`define TWCP_PIN_RESET 1'b0

`endif

// file: core/twcp_pkg.sv
// types shared by the three-wire control port modules
`include "twcp_consts.svh"

package twcp_pkg;

    // ==================================================================
    // control word and operating states
    typedef logic [`TWCP_WORD_W-1:0] twcp_word_t;

    typedef enum logic [1:0] {
        TWCP_ST_INIT = 2'b00,
        TWCP_ST_SOFT = 2'b01,
        TWCP_ST_HARD = 2'b10
    } twcp_state_e;

    // ==================================================================
    // state of the system-clock side
    typedef struct packed {
        twcp_state_e state;
        logic [`TWCP_INIT_CNT_W-1:0] init_cnt;
        logic latch_d1;
        logic latch_d2;
        twcp_word_t word;
        logic update;
    } twcp_main_s;

    // state of the link side shift register
    typedef struct packed {
        twcp_word_t bits;
    } twcp_shift_s;

endpackage

// file: core/twcp_sync.sv
// two flip-flop synchroniser for levels entering the system clock domain
`timescale 1ns/1ps
`default_nettype none

module twcp_sync #(
    parameter int W = 1,
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } twcp_sync_s;

    twcp_sync_s q, d;

    // ==================================================================
    // the meta stage feeds only the second stage
    always_comb begin
        d = q;
        d.meta = async_in;
        d.sync = q.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q <= {(2 * W){RESET_VAL}};
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.sync;

endmodule

`default_nettype wire

// file: core/twcp_shift.sv
// serial-to-parallel shift register clocked by the host shift clock
`timescale 1ns/1ps
`default_nettype none
`include "twcp_consts.svh"

module twcp_shift (
    input wire logic control_shift_clock,
    input wire logic control_serial_input,
    output var twcp_pkg::twcp_word_t parallel_word
);
    import twcp_pkg::*;

    twcp_shift_s q, d;

    // ==================================================================
    // msb first: older bits move up, newest lands in bit 0
    always_comb begin
        d = q;
        d.bits = {q.bits[`TWCP_WORD_W-2:0], control_serial_input};
    end

    // no reset here on purpose: the register keeps shifting through init
    always_ff @(posedge control_shift_clock) begin
        q <= d;
    end

    assign parallel_word = q.bits;

    // ==================================================================
    // checks; edge counter exists only to let them wait for a full word
    logic [4:0] seen = 5'h00;

    always_ff @(posedge control_shift_clock) begin
        if (seen != 5'h10) begin
            seen <= seen + 5'h01;
        end
    end

    property p_msb_first;
        @(posedge control_shift_clock)
        (seen == 5'h10) |-> (q.bits[15] == $past(control_serial_input, 16))
            && (q.bits[0] == $past(control_serial_input, 1));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("shift order wrong");

endmodule

`default_nettype wire

// file: core/twcp_control_port.sv
// three-wire write-only control port with reset init and mode select
`timescale 1ns/1ps
`default_nettype none
`include "twcp_consts.svh"

module twcp_control_port #(
    parameter int INIT_CYCLES = `TWCP_INIT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic control_shift_clock,
    input wire logic control_serial_input,
    input wire logic control_latch_strobe,
    input wire logic mode_select_software,
    input wire logic ext_reset_n,
    output var twcp_pkg::twcp_word_t control_word,
    output logic control_update,
    output logic init_done,
    output logic software_mode_active
);
    import twcp_pkg::*;

    localparam logic [`TWCP_INIT_CNT_W-1:0] INIT_LAST =
        `TWCP_INIT_CNT_W'(INIT_CYCLES - 1);

    // ==================================================================
    // link side: the shift register lives on the host shift clock

    twcp_word_t shift_word;

    // the host clock may stop between words; nothing here relies on
    // edges after the last bit, the word simply sits until sampled
    twcp_shift u_shift (
        .control_shift_clock(control_shift_clock),
        .control_serial_input(control_serial_input),
        .parallel_word(shift_word)
    );

    // ==================================================================
    // crossings into the system clock domain

    twcp_word_t word_sync;
    logic latch_sync;
    logic mode_sync;
    logic ext_ok_sync;

    // the word is quasi-static: the host stops shifting before it raises
    // the strobe, and the strobe path below has one stage more than this
    twcp_sync #(
        .W(`TWCP_WORD_W),
        .RESET_VAL(`TWCP_PIN_RESET)
    ) u_word_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(shift_word),
        .sync_out(word_sync)
    );

    // latch strobe level; its edge is found after the third stage, latch_d1
    twcp_sync #(
        .W(1),
        .RESET_VAL(`TWCP_PIN_RESET)
    ) u_latch_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(control_latch_strobe),
        .sync_out(latch_sync)
    );

    // mode select pin, high selects software mode
    twcp_sync #(
        .W(1),
        .RESET_VAL(`TWCP_PIN_RESET)
    ) u_mode_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(mode_select_software),
        .sync_out(mode_sync)
    );

    // external reset pin, idle high so a clean start is not held in init
    twcp_sync #(
        .W(1),
        .RESET_VAL(`TWCP_EXT_RESET_IDLE)
    ) u_ext_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(ext_reset_n),
        .sync_out(ext_ok_sync)
    );

    // ==================================================================
    // control state

    twcp_main_s q, d;
    logic latch_rise;

    // strobe edge, seen one stage after the synchroniser output so that
    // the word copy above has had a full cycle to settle
    assign latch_rise = q.latch_d1 & ~q.latch_d2;

    // next state: init counting, mode tracking and the latch copy
    always_comb begin
        d = q;
        d.latch_d1 = latch_sync;
        d.latch_d2 = q.latch_d1;
        d.update = 1'b0;
        if (!ext_ok_sync) begin
            // external reset restarts the whole initialization period
            d.state = TWCP_ST_INIT;
            d.init_cnt = '0;
        end else begin
            unique case (q.state)
                TWCP_ST_INIT: begin
                    // strobe edges here are dropped, the word stays put
                    if (q.init_cnt == INIT_LAST) begin
                        d.state = mode_sync ? TWCP_ST_SOFT : TWCP_ST_HARD;
                    end else begin
                        d.init_cnt = q.init_cnt + 1'b1;
                    end
                end
                TWCP_ST_SOFT: begin
                    if (!mode_sync) begin
                        d.state = TWCP_ST_HARD;
                    end else if (latch_rise) begin
                        // stale bits are copied too; no activity check
                        d.word = word_sync;
                        d.update = 1'b1;
                    end
                end
                TWCP_ST_HARD: begin
                    // strobe and shift clock have no effect in this mode
                    if (mode_sync) begin
                        d.state = TWCP_ST_SOFT;
                    end
                end
                default: begin
                    // illegal code: fall back to a fresh initialization
                    d.state = TWCP_ST_INIT;
                    d.init_cnt = '0;
                end
            endcase
        end
    end

    // one register for all control state; reset loads constants only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q.state <= TWCP_ST_INIT;
            q.init_cnt <= '0;
            q.latch_d1 <= 1'b0;
            q.latch_d2 <= 1'b0;
            q.word <= `TWCP_WORD_RESET;
            q.update <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ==================================================================
    // outputs, all from the state register

    assign control_word = q.word;
    assign control_update = q.update;
    assign init_done = (q.state != TWCP_ST_INIT);
    assign software_mode_active = (q.state == TWCP_ST_SOFT);

    // ==================================================================
    // checks

    default clocking cb_sys @(posedge clk_sys);
    endclocking

    default disable iff (reset);

    // a strobe edge in software mode lands the synchronised word
    property p_latch_copies;
        (q.state == TWCP_ST_SOFT && mode_sync && ext_ok_sync && latch_rise)
            |=> (control_update && control_word == $past(word_sync));
    endproperty
    a_latch_copies: assert property (p_latch_copies) else $error("latch did not copy word");

    // the update pulse is exactly one cycle wide, stale data or not
    property p_stale_latch;
        (q.state == TWCP_ST_SOFT && mode_sync && ext_ok_sync && latch_rise)
            |=> control_update ##1 !control_update;
    endproperty
    a_stale_latch: assert property (p_stale_latch) else $error("update pulse wrong width");

    // nothing reaches the word while initialization runs
    property p_init_blocks;
        (q.state == TWCP_ST_INIT) |=> (!control_update && $stable(control_word));
    endproperty
    a_init_blocks: assert property (p_init_blocks) else $error("word written during init");

    // after reset release the init period lasts at least eight cycles
    property p_init_length;
        $fell(reset) |-> !init_done [*8];
    endproperty
    a_init_length: assert property (p_init_length) else $error("init period too short");

    // init ends exactly one cycle after the counter reaches its last value
    property p_init_ends;
        (q.state == TWCP_ST_INIT && q.init_cnt == INIT_LAST && ext_ok_sync)
            |=> (init_done && software_mode_active == $past(mode_sync));
    endproperty
    a_init_ends: assert property (p_init_ends) else $error("init did not end on time");

    // hardware mode leaves the word alone whatever the strobe does
    property p_hard_ignores;
        (q.state == TWCP_ST_HARD) |=> (!control_update && $stable(control_word));
    endproperty
    a_hard_ignores: assert property (p_hard_ignores) else $error("word changed in hardware mode");

    // mode select follows the synchronised pin once init is over
    property p_mode_select;
        (init_done && ext_ok_sync && $changed(mode_sync))
            |=> (software_mode_active == $past(mode_sync));
    endproperty
    a_mode_select: assert property (p_mode_select) else $error("mode select not followed");

    // the word only moves together with an update pulse
    property p_word_held;
        !$stable(control_word) |-> control_update;
    endproperty
    a_word_held: assert property (p_word_held) else $error("word changed without latch");

    // software mode is needed for any update
    property p_soft_only;
        control_update |-> ($past(q.state) == TWCP_ST_SOFT && $past(mode_sync));
    endproperty
    a_soft_only: assert property (p_soft_only) else $error("update outside software mode");

    // ==================================================================
    // further checks: latch path, init period and mode tracking

    localparam logic [`TWCP_INIT_CNT_W-1:0] INIT_STEP = `TWCP_INIT_CNT_W'(1);

    // cycles spent in init since the last restart; kept apart from the
    // state counter so that the period length is judged on its own
    logic [`TWCP_INIT_CNT_W:0] init_age_q;

    always_ff @(posedge clk_sys) begin
        if (reset || !ext_ok_sync) begin
            init_age_q <= '0;
        end else if (q.state == TWCP_ST_INIT) begin
            init_age_q <= init_age_q + 1'b1;
        end
    end

    // the update pulse never stretches into a second cycle
    property p_update_pulse;
        control_update |=> !control_update;
    endproperty
    a_update_pulse: assert property (p_update_pulse) else $error("update too long");

    // a synchronised strobe rise always reaches the edge detector
    property p_rise_seen;
        $rose(latch_sync) |=> latch_rise;
    endproperty
    a_rise_seen: assert property (p_rise_seen) else $error("strobe edge lost");

    // every update pulse has a strobe edge behind it
    property p_update_cause;
        control_update |-> $past(latch_rise);
    endproperty
    a_update_cause: assert property (p_update_cause) else $error("update without strobe");

    // the word taken is the synchronised shift register, stale or fresh
    property p_word_source;
        control_update |-> (control_word == $past(word_sync));
    endproperty
    a_word_source: assert property (p_word_source) else $error("wrong word copied");

    // strobe edges outside software mode are dropped
    property p_rise_not_soft;
        (latch_rise && q.state != TWCP_ST_SOFT) |=> !control_update;
    endproperty
    a_rise_not_soft: assert property (p_rise_not_soft) else $error("strobe acted");

    // without a strobe edge the word keeps its value
    property p_no_rise_hold;
        !latch_rise |=> (!control_update && $stable(control_word));
    endproperty
    a_no_rise_hold: assert property (p_no_rise_hold) else $error("word not held");

    // a low external reset restarts the init count from zero
    property p_ext_restart;
        !ext_ok_sync |=> (q.state == TWCP_ST_INIT && q.init_cnt == '0);
    endproperty
    a_ext_restart: assert property (p_ext_restart) else $error("init not restarted");

    // the external reset never touches the control word
    property p_ext_keeps_word;
        !ext_ok_sync |=> (!control_update && $stable(control_word));
    endproperty
    a_ext_keeps_word: assert property (p_ext_keeps_word) else $error("word hit by reset");

    // the init count moves by one per cycle until its last value
    property p_count_steps;
        (q.state == TWCP_ST_INIT && ext_ok_sync && q.init_cnt != INIT_LAST)
            |=> (q.init_cnt == $past(q.init_cnt) + INIT_STEP);
    endproperty
    a_count_steps: assert property (p_count_steps) else $error("init count skipped");

    // init never outlasts its period
    property p_init_bound;
        (q.state == TWCP_ST_INIT) |-> (init_age_q < INIT_CYCLES);
    endproperty
    a_init_bound: assert property (p_init_bound) else $error("init too long");

    // init ends after exactly the configured number of cycles
    property p_init_exact;
        $rose(init_done) |-> (init_age_q == INIT_CYCLES);
    endproperty
    a_init_exact: assert property (p_init_exact) else $error("init length wrong");

    // once done, init stays done while the external reset is idle
    property p_done_sticky;
        (init_done && ext_ok_sync) |=> init_done;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("init restarted");

    // only the three defined state codes ever appear
    property p_state_legal;
        q.state inside {TWCP_ST_INIT, TWCP_ST_SOFT, TWCP_ST_HARD};
    endproperty
    a_state_legal: assert property (p_state_legal) else $error("illegal state");

    // a low mode pin after init always leaves software mode
    property p_mode_hard;
        (init_done && ext_ok_sync && !mode_sync) |=> !software_mode_active;
    endproperty
    a_mode_hard: assert property (p_mode_hard) else $error("port still active");

    // a high mode pin after init always gives software mode
    property p_mode_soft;
        (init_done && ext_ok_sync && mode_sync) |=> software_mode_active;
    endproperty
    a_mode_soft: assert property (p_mode_soft) else $error("software mode missed");

endmodule

`default_nettype wire

// file: tb/twcp_host.sv
// host model that drives the three serial control lines
`timescale 1ns/1ps
`default_nettype none

module twcp_host (
    output logic control_shift_clock,
    output logic control_serial_input,
    output logic control_latch_strobe
);
    // ==================================================================
    // idle levels
    // clock and strobe rest high so nothing is clocked or latched between frames
    initial begin
        control_shift_clock = 1'b1;
        control_serial_input = 1'b0;
        control_latch_strobe = 1'b1;
    end

    // ==================================================================
    // frame tasks
    // odd offset keeps the link edges unrelated to the system clock
    task automatic begin_frame(input bit low_method);
        #13;
        if (low_method) begin
            control_latch_strobe = 1'b0;
            #100;
        end
    endtask

    // one data bit per rising edge, 160 ns period, data held through the edge
    task automatic shift_bit(input logic b);
        control_shift_clock = 1'b0;
        control_serial_input = b;
        #80;
        control_shift_clock = 1'b1;
        #80;
    endtask

    // data line released by inverting it; strobe rises only after shifting stopped
    task automatic end_frame(input bit low_method);
        control_serial_input = ~control_serial_input;
        #100;
        if (!low_method) begin
            control_latch_strobe = 1'b0;
            #100;
        end
        control_latch_strobe = 1'b1;
        #100;
    endtask
endmodule
`default_nettype wire

// file: tb/three_wire_control_port_test.sv
// self-checking bench of the three-wire control port
`timescale 1ns/1ps
`default_nettype none

module three_wire_control_port_test;
    import twcp_pkg::*;
    localparam int INIT_N = 16;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic mode_sw = 1'b1;
    logic ext_n = 1'b0;
    wire logic sclk;
    wire logic sdata;
    wire logic strobe;
    twcp_word_t control_word;
    logic control_update;
    logic init_done;
    logic sw_active;
    int fail_count = 0;
    int n_tests = 0;
    int upd_cnt = 0;
    int c0 = 0;

    // ==================================================================
    // clock, partner, design
    always #20 clk_sys = ~clk_sys;

    twcp_host i_host (
        .control_shift_clock(sclk),
        .control_serial_input(sdata),
        .control_latch_strobe(strobe)
    );

    twcp_control_port #(.INIT_CYCLES(INIT_N)) i_dut (
        .clk_sys(clk_sys),
        .reset(reset),
        .control_shift_clock(sclk),
        .control_serial_input(sdata),
        .control_latch_strobe(strobe),
        .mode_select_software(mode_sw),
        .ext_reset_n(ext_n),
        .control_word(control_word),
        .control_update(control_update),
        .init_done(init_done),
        .software_mode_active(sw_active)
    );

    // counts update pulses; a registered pulse is seen once per edge
    always @(posedge clk_sys) begin
        if (control_update === 1'b1) upd_cnt++;
    end

    // ==================================================================
    // helpers
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input twcp_word_t seen, input twcp_word_t exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic send_word(input twcp_word_t w, input bit m);
        c0 = upd_cnt;
        i_host.begin_frame(m);
        for (int i = 15; i >= 0; i--) i_host.shift_bit(w[i]);
        i_host.end_frame(m);
    endtask

    // a strobe pulse with no shifting in front of it
    task automatic latch_only();
        c0 = upd_cnt;
        i_host.begin_frame(1'b0);
        i_host.end_frame(1'b0);
    endtask

    // bounded wait for an update pulse, then judge count and word
    task automatic expect_latch(input bit want, input twcp_word_t exp);
        for (int i = 0; i < 30 && upd_cnt == c0; i++) @(posedge clk_sys);
        check("updates", 16'(upd_cnt - c0), 16'(want));
        check("control word", control_word, exp);
    endtask

    task automatic wait_init();
        for (int i = 0; i < 80 && init_done !== 1'b1; i++) @(posedge clk_sys);
        check("init done", {15'h0, init_done}, 16'h0001);
    endtask

    // ==================================================================
    // scenarios
    // a word sent while the external reset holds init is shifted but not written
    task automatic t_init_activity();
        send_word(16'ha5c3, 1'b0);
        expect_latch(1'b0, 16'h0000);
        check("init done", {15'h0, init_done}, 16'h0000);
        @(posedge clk_sys) ext_n <= 1'b1;
        wait_init();
        check("word after init", control_word, 16'h0000);
        check("sw mode", {15'h0, sw_active}, 16'h0001);
        latch_only();
        expect_latch(1'b1, 16'ha5c3);
    endtask

    // back to back words with both strobe methods, msb first
    task automatic t_methods();
        twcp_word_t words [4] = '{16'h8001, 16'h7ffe, 16'h0f35, 16'hc0de};
        for (int i = 0; i < 4; i++) begin
            send_word(words[i], i[0]);
            expect_latch(1'b1, words[i]);
        end
    endtask

    // twenty edges before the strobe keep only the last sixteen bits
    task automatic t_overrun();
        twcp_word_t w = 16'h1234;
        c0 = upd_cnt;
        i_host.begin_frame(1'b1);
        for (int i = 0; i < 4; i++) i_host.shift_bit(1'b1);
        for (int i = 15; i >= 0; i--) i_host.shift_bit(w[i]);
        i_host.end_frame(1'b1);
        expect_latch(1'b1, 16'h1234);
        c0 = upd_cnt;
        repeat (50) @(posedge clk_sys);
        check("held updates", 16'(upd_cnt - c0), 16'h0000);
        check("held word", control_word, 16'h1234);
    endtask

    // hardware mode ignores the port; software mode comes back without a new init
    task automatic t_hardware();
        @(posedge clk_sys) mode_sw <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check("sw mode", {15'h0, sw_active}, 16'h0000);
        send_word(16'hffff, 1'b0);
        expect_latch(1'b0, 16'h1234);
        @(posedge clk_sys) mode_sw <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check("sw mode", {15'h0, sw_active}, 16'h0001);
        send_word(16'h5aa5, 1'b1);
        expect_latch(1'b1, 16'h5aa5);
    endtask

    // ==================================================================
    // main sequence and watchdog
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        t_init_activity();
        t_methods();
        t_overrun();
        t_hardware();
        stop_test();
    end

    // whole run needs about 32 us; over six times that means a hang
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
